// File: rtl/crcg_pkg.sv
// Purpose: Shared constants for the checksum generator engine
// Assumes: One system clock, byte-serial checksum update
// Notes: Polynomial codes and reset values live here
package crcg_pkg;
	typedef enum logic [1:0] {
		CRCG_POLY_CCITT = 2'b00,
		CRCG_POLY_16 = 2'b01,
		CRCG_POLY_32 = 2'b10
	} crcg_poly_e;

	typedef enum logic [1:0] {
		CRCG_SIZE_8 = 2'b00,
		CRCG_SIZE_16 = 2'b01,
		CRCG_SIZE_32 = 2'b10
	} crcg_size_e;

	localparam logic [31:0] CRCG_POLY_CCITT_VAL = 32'h00001021;
	localparam logic [31:0] CRCG_POLY_16_VAL = 32'h00008005;
	localparam logic [31:0] CRCG_POLY_32_VAL = 32'h04c11db7;
	localparam logic [31:0] CRCG_SEED_RESET = 32'h00000000;
	localparam logic [2:0] CRCG_STEPS_8 = 3'h1;
	localparam logic [2:0] CRCG_STEPS_16 = 3'h2;
	localparam logic [2:0] CRCG_STEPS_32 = 3'h4;
	localparam int CRCG_BYTE_W = 8;
endpackage

// File: rtl/crcg_byte_step.sv
// Purpose: One byte step of the checksum update, combinational
// Assumes: State is right-aligned for 16-bit polynomials in the low half
// Notes: MSB-first shift within the byte
`timescale 1ns/1ps
module crcg_byte_step (
	// Current state and input
	input wire logic [31:0] state_in,
	input wire logic [7:0] data_in,
	input wire crcg_pkg::crcg_poly_e poly_in,
	// Updated state
	output logic [31:0] state_out
);
	import crcg_pkg::*;

	always_comb begin
		logic [31:0] s;
		logic [31:0] p;
		logic fb;
		s = state_in;
		p = CRCG_POLY_32_VAL;
		fb = 1'b0;
		unique case (poly_in)
			CRCG_POLY_CCITT: p = CRCG_POLY_CCITT_VAL;
			CRCG_POLY_16: p = CRCG_POLY_16_VAL;
			default: p = CRCG_POLY_32_VAL;
		endcase
		for (int i = 7; i >= 0; i--) begin
			if (poly_in == CRCG_POLY_32) begin
				fb = s[31] ^ data_in[i];
				s = {s[30:0], 1'b0} ^ (fb ? p : 32'h00000000);
			end else begin
				fb = s[15] ^ data_in[i];
				s = {16'h0000, s[14:0], 1'b0} ^ (fb ? p : 32'h00000000);
			end
		end
		state_out = s;
	end
endmodule // crcg_byte_step

// File: rtl/crcg_engine.sv
// Purpose: Checksum generator fed by processor or DMA writes
// Assumes: Writes come from logic on CLK_SYS_IN; no gap between writes
// Notes: Busy stalls the writer while a multi-byte write drains
// Functional notes
// - Three selectable polynomials: CCITT, 16, 32
// - Input byte optionally bit-reversed and/or complemented
// - Result optionally bit-reversed and/or complemented
// - Seed loads as starting checksum state
// - Back-to-back byte writes accepted without required gaps
// - Byte, halfword or word writes by size
// - Byte write folds in one cycle
// - Halfword write takes two byte steps
// - Word write takes four byte steps
`timescale 1ns/1ps
module crcg_engine (
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	// Configuration
	input wire crcg_pkg::crcg_poly_e POLY_SEL_IN,
	input wire logic DATA_REV_IN,
	input wire logic DATA_INV_IN,
	input wire logic SUM_REV_IN,
	input wire logic SUM_INV_IN,
	// Seed load
	input wire logic [31:0] SEED_IN,
	input wire logic SEED_LOAD_IN,
	// Data write
	input wire logic WR_VALID_IN,
	input wire crcg_pkg::crcg_size_e WR_SIZE_IN,
	input wire logic [31:0] WR_DATA_IN,
	output logic WR_READY_OUT,
	// Result
	output logic [31:0] SUM_OUT,
	output logic SUM_VALID_OUT
);
	import crcg_pkg::*;

	// Synchronised reset
	logic rst_meta;
	logic rst_n;
	// Checksum state and its one-byte update
	logic [31:0] state;
	logic [31:0] next_state;
	// Multi-byte write in flight
	logic [31:0] hold;
	logic [31:0] next_hold;
	logic [2:0] left;
	logic [2:0] next_left;
	logic [2:0] steps;
	logic take;
	logic busy;
	logic step_now;
	// Byte path into the step
	logic [7:0] cur_byte;
	logic [7:0] fed_byte;
	// Result path
	logic [31:0] mask;
	logic [31:0] sum_raw;
	logic [31:0] sum_rev;
	logic [31:0] sum_shaped;
	logic next_valid;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rev8[i] = v[7 - i];
	endfunction

	function automatic logic [31:0] rev32(input logic [31:0] v);
		for (int i = 0; i < 32; i++)
			rev32[i] = v[31 - i];
	endfunction

	// Code 3 falls to the 32-bit window; the step logic shifts it on the 16-bit path
	function automatic logic [31:0] sum_mask(input crcg_poly_e sel);
		if (sel == CRCG_POLY_CCITT || sel == CRCG_POLY_16) begin
			sum_mask = 32'h0000ffff;
		end else begin
			sum_mask = 32'hffffffff;
		end
	endfunction

	// Size code 3 is illegal and handled as a byte
	function automatic logic [2:0] size_steps(input crcg_size_e sz);
		unique case (sz)
			CRCG_SIZE_16: size_steps = CRCG_STEPS_16;
			CRCG_SIZE_32: size_steps = CRCG_STEPS_32;
			default: size_steps = CRCG_STEPS_8;
		endcase
	endfunction

	// Reset released through two flops
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Busy while bytes of an earlier write remain; taking a write on
	// the last step would steal that write's final byte slot
	assign busy = left != 3'h0;
	assign WR_READY_OUT = rst_n && !SEED_LOAD_IN && !busy;
	assign take = WR_VALID_IN && WR_READY_OUT;
	assign step_now = take || busy;
	assign steps = size_steps(WR_SIZE_IN);
	assign mask = sum_mask(POLY_SEL_IN);

	// Byte in flight: new write's low byte, else the shifted remainder
	assign cur_byte = take ? WR_DATA_IN[7:0] : hold[7:0];

	always_comb begin
		fed_byte = DATA_REV_IN ? rev8(cur_byte) : cur_byte;
		if (DATA_INV_IN)
			fed_byte = ~fed_byte;
	end

	crcg_byte_step u_step (
		.state_in(state),
		.data_in(fed_byte),
		.poly_in(POLY_SEL_IN),
		.state_out(next_state)
	);

	// Remaining byte count and shift holder; a seed drops pending bytes
	always_comb begin
		next_left = left;
		next_hold = hold;
		if (SEED_LOAD_IN) begin
			next_left = 3'h0;
		end else if (take) begin
			next_left = steps - 3'h1;
			next_hold = {8'h00, WR_DATA_IN[31:8]};
		end else if (busy) begin
			next_left = left - 3'h1;
			next_hold = {8'h00, hold[31:8]};
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			left <= 3'h0;
		end else begin
			left <= next_left;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			hold <= 32'h00000000;
		end else begin
			hold <= next_hold;
		end
	end

	// Checksum state; seed overrides any pending step
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			state <= CRCG_SEED_RESET;
		end else if (SEED_LOAD_IN) begin
			state <= SEED_IN;
		end else if (step_now) begin
			state <= next_state;
		end
	end

	// Result view; 16-bit polys use the low half only
	always_comb begin
		sum_raw = state & mask;
		sum_rev = rev32(sum_raw);
		if (!mask[16]) begin
			sum_rev = {16'h0000, sum_rev[31:16]};
		end
		sum_shaped = SUM_REV_IN ? sum_rev : sum_raw;
		if (SUM_INV_IN) begin
			sum_shaped = ~sum_shaped;
		end
		sum_shaped = sum_shaped & mask;
	end

	// Registered, so the sum trails the state by one cycle
	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			SUM_OUT <= 32'h00000000;
		end else begin
			SUM_OUT <= sum_shaped;
		end
	end

	// Sum valid once all steps are done and nothing new started
	assign next_valid = !busy && !take && !SEED_LOAD_IN;

	always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
		if (!rst_n) begin
			SUM_VALID_OUT <= 1'b0;
		end else begin
			SUM_VALID_OUT <= next_valid;
		end
	end
endmodule // crcg_engine

// File: verif/crcg_engine_checker.sv
// Purpose: Write handshake checks
// Assumes: One clock
// Notes: Bound in tb_top
`timescale 1ns/1ps
module crcg_chk (
	// Watched ports
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	input wire logic SEED_LOAD_IN,
	input wire logic WR_VALID_IN,
	input wire crcg_pkg::crcg_size_e WR_SIZE_IN,
	input wire logic WR_READY_OUT,
	input wire logic SUM_VALID_OUT
);
	import crcg_pkg::*;
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);
	sequence tk(crcg_size_e z);
		WR_VALID_IN && WR_READY_OUT && WR_SIZE_IN == z;
	endsequence
	property p_b; tk(CRCG_SIZE_8) |=> WR_READY_OUT; endproperty
	a_b: assert property (p_b) else $error("b");
	property p_h; tk(CRCG_SIZE_16) |=> !WR_READY_OUT ##1 WR_READY_OUT;
	endproperty
	a_h: assert property (p_h) else $error("h");
	property p_w; tk(CRCG_SIZE_32) |=> (!WR_READY_OUT)[*3] ##1 WR_READY_OUT;
	endproperty
	a_w: assert property (p_w) else $error("w");
	property p_s; SEED_LOAD_IN |-> !WR_READY_OUT; endproperty
	a_s: assert property (p_s) else $error("s");
	property p_i; SUM_VALID_OUT && !SEED_LOAD_IN |-> WR_READY_OUT; endproperty
	a_i: assert property (p_i) else $error("i");
	property p_x; tk(CRCG_SIZE_32) |-> ##2 !SUM_VALID_OUT; endproperty
	a_x: assert property (p_x) else $error("x");
	property p_d; tk(CRCG_SIZE_32) ##4 !WR_VALID_IN |-> ##1 SUM_VALID_OUT;
	endproperty
	a_d: assert property (p_d) else $error("d");
	property p_e; tk(CRCG_SIZE_8) ##1 !WR_VALID_IN |-> ##[0:1] SUM_VALID_OUT;
	endproperty
	a_e: assert property (p_e) else $error("e");
endmodule // crcg_chk

// File: verif/crcg_writer.sv
// Purpose: Writer model
// Assumes: Drives at falling edge
// Notes: Released data inverts
`timescale 1ns/1ps
module crcg_writer (
	// Handshake
	input wire logic clk_in,
	input wire logic rdy_in,
	// Request
	output logic v_out = 1'b0,
	output crcg_pkg::crcg_size_e z_out = crcg_pkg::CRCG_SIZE_8,
	output logic [31:0] d_out = 32'h0
);
	import crcg_pkg::*;
	task automatic put(crcg_size_e z, logic [31:0] x);
		@(negedge clk_in);
		v_out = 1'b1;
		z_out = z;
		d_out = x;
		while (rdy_in !== 1'b1) @(negedge clk_in);
		@(posedge clk_in);
	endtask
	task automatic idle();
		@(negedge clk_in);
		v_out = 1'b0;
		d_out = ~d_out;
	endtask
endmodule // crcg_writer

// File: verif/tb_top.sv
// Purpose: Engine bench
// Assumes: Inputs move at falling edge
// Notes: Reference folds low byte first
`timescale 1ns/1ps
module tb_top;
	import crcg_pkg::*;
	logic CLK_SYS_IN = 1'b0;
	logic RST_N_IN = 1'b0;
	logic SEED_LOAD_IN = 1'b0;
	logic [3:0] cfg = 4'h0;
	logic DATA_REV_IN, DATA_INV_IN, SUM_REV_IN, SUM_INV_IN;
	logic WR_VALID_IN, WR_READY_OUT, SUM_VALID_OUT;
	logic [31:0] SEED_IN = 32'h0;
	logic [31:0] WR_DATA_IN, SUM_OUT, ex, m, p;
	crcg_poly_e POLY_SEL_IN = CRCG_POLY_CCITT;
	crcg_size_e WR_SIZE_IN;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	assign {SUM_INV_IN, SUM_REV_IN, DATA_INV_IN, DATA_REV_IN} = cfg;
	assign m = POLY_SEL_IN == CRCG_POLY_32 ? 32'hffffffff : 32'h0000ffff;
	crcg_writer i_wr (.clk_in(CLK_SYS_IN), .rdy_in(WR_READY_OUT),
		.v_out(WR_VALID_IN), .z_out(WR_SIZE_IN), .d_out(WR_DATA_IN));
	crcg_engine i_dut (.*);
	initial forever #20 CLK_SYS_IN = ~CLK_SYS_IN;
	always @(posedge CLK_SYS_IN) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic put(crcg_size_e z, logic [31:0] x);
		logic [7:0] b;
		p = POLY_SEL_IN == CRCG_POLY_32 ? CRCG_POLY_32_VAL :
			POLY_SEL_IN == CRCG_POLY_16 ? CRCG_POLY_16_VAL : CRCG_POLY_CCITT_VAL;
		for (int n = 0; n < (1 << z); n++) begin
			b = x[8 * n +: 8];
			if (cfg[0]) b = {<<{b}};
			b = b ^ {8{cfg[1]}};
			for (int i = 7; i >= 0; i--)
				ex = ((ex << 1) ^ ((ex[m[16] ? 31 : 15] ^ b[i]) ? p : 32'h0)) & m;
		end
		i_wr.put(z, x);
	endtask
	task automatic chk();
		logic [31:0] r;
		i_wr.idle();
		repeat (2) @(negedge CLK_SYS_IN);
		while (SUM_VALID_OUT !== 1'b1) @(negedge CLK_SYS_IN);
		for (int i = 0; i < 32; i++) r[i] = ex[31 - i];
		if (!m[16]) r = r >> 16;
		if (!cfg[2]) r = ex;
		r = (r ^ {32{cfg[3]}}) & m;
		samples_checked++;
		if ((SUM_OUT & m) !== r) begin
			bad_count++;
			$display("unexpected at %0t: sum %h want %h", $time, SUM_OUT, r);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge CLK_SYS_IN);
		RST_N_IN = 1'b1;
		repeat (3) @(negedge CLK_SYS_IN);
		for (int k = 0; k < 16; k++) begin
			POLY_SEL_IN = crcg_poly_e'(k % 3);
			cfg = k[3:0];
			@(negedge CLK_SYS_IN);
			SEED_IN = 32'h5a3c96e1 + k;
			SEED_LOAD_IN = 1'b1;
			ex = SEED_IN & m;
			@(negedge CLK_SYS_IN);
			SEED_LOAD_IN = 1'b0;
			put(CRCG_SIZE_8, 32'hdeadbe00 + k);
			put(CRCG_SIZE_16, 32'hffff1234 + k);
			put(CRCG_SIZE_32, 32'h80017f00 - k);
			chk();
			put(crcg_size_e'(k % 3), 32'h0f1e2d3c * k);
			chk();
			$display("test %0d done", k);
		end
		complete_run();
	end
endmodule // tb_top
bind crcg_engine crcg_chk i_chk (.*);
